// >>> discrete_iir_filter.sv
// Sampled recursive filter, one-pole or two-pole form, fixed-point datapath
//
// How it works
// [RULE1] One-pole form: output = current-input weight * input + previous-input weight * previous input - denominator weight * previous output.
// [RULE2] Two-pole form: output = three input weights on current, one-back and two-back inputs minus two output weights on one-back and two-back outputs.
// [RULE3] One-pole form uses exactly three coefficients: two input weights and one output weight.
// [RULE4] Two-pole form uses five coefficients: three input weights and two output weights.
// [RULE5] The output starts at a configurable start value, which also fills the past output history.
// [RULE6] A configurable acquisition time paces when each input is taken and a new output made.
// [RULE7] Coefficients, samples and history are signed fixed point, and input history clears to zero at start.
module discrete_iir_filter
    import iir_filter_pkg::*;
#(
    parameter int DW        = DATA_WIDTH,
    parameter int CW        = COEF_WIDTH,
    parameter int FRAC      = COEF_FRAC,
    parameter int ACQ_COUNT = ACQ_CYCLES
)
(
    input  wire logic                 clk_sys,             // System clock, 40 MHz
    input  wire logic                 nrst,                // Synchronous reset, active low
    input  wire logic                 pole_two,            // 1: two-pole form, 0: one-pole form
    input  wire logic signed [CW-1:0] numer_weight_newest, // Current input weight, two-pole
    input  wire logic signed [CW-1:0] numer_weight_middle, // One-back (two-pole) or current input
    input  wire logic signed [CW-1:0] numer_weight_oldest, // Two-back (two-pole) or previous input
    input  wire logic signed [CW-1:0] denom_weight_newer,  // One-back output weight, two-pole
    input  wire logic signed [CW-1:0] denom_weight_oldest, // Two-back (two-pole) or previous output
    input  wire logic signed [DW-1:0] output_start_value,  // Initial output and output history
    input  wire logic signed [DW-1:0] in_data,             // Upstream sample
    output logic signed [DW-1:0]      out_data,            // Filtered sample, held between ticks
    output logic                      out_valid            // One-cycle pulse per new sample if ACQ_COUNT > 1, held high every cycle if ACQ_COUNT is 1
);

    localparam int ACCW = DW + CW + 3;
    localparam int CNTW = $clog2(ACQ_COUNT + 1);
    localparam logic [CNTW-1:0] CNT_LAST = CNTW'(ACQ_COUNT - 1);
    localparam logic signed [ACCW-1:0] SAT_MAX = ACCW'((2 ** (DW - 1)) - 1);
    localparam logic signed [ACCW-1:0] SAT_MIN = ACCW'(-(2 ** (DW - 1)));

    ////////////////////////////////////////////////////////////////////////////////
    // Arithmetic

    // Clamp instead of wrap: a wrapped sum would flip sign and ring in the loop
    function automatic logic signed [DW-1:0] sat_q(input logic signed [ACCW-1:0] acc);
        logic signed [ACCW-1:0] shifted;
        shifted = acc >>> FRAC;
        if (shifted > SAT_MAX)
            return SAT_MAX[DW-1:0];
        else if (shifted < SAT_MIN)
            return SAT_MIN[DW-1:0];
        else
            return shifted[DW-1:0];
    endfunction

    function automatic logic signed [ACCW-1:0] mul(input logic signed [CW-1:0] w,
                                                   input logic signed [DW-1:0] x);
        return ACCW'(w) * ACCW'(x);
    endfunction

    function automatic logic signed [DW-1:0] filt_calc(
        input logic                 two,
        input logic signed [DW-1:0] cur,
        input logic signed [DW-1:0] ih1,
        input logic signed [DW-1:0] ih2,
        input logic signed [DW-1:0] oh1,
        input logic signed [DW-1:0] oh2,
        input logic signed [CW-1:0] n_new,
        input logic signed [CW-1:0] n_mid,
        input logic signed [CW-1:0] n_old,
        input logic signed [CW-1:0] d_new,
        input logic signed [CW-1:0] d_old);
        logic signed [ACCW-1:0] acc;
        acc = '0;
        if (two)
        begin
            acc = mul(n_new, cur) + mul(n_mid, ih1) + mul(n_old, ih2)
                - mul(d_new, oh1) - mul(d_old, oh2);                  // RULE2 RULE4
        end
        else
        begin
            acc = mul(n_mid, cur) + mul(n_old, ih1) - mul(d_old, oh1); // RULE1 RULE3
        end
        return sat_q(acc);                                             // RULE7
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // State

    logic [CNTW-1:0]        acq_count;
    logic [CNTW-1:0]        next_acq_count;
    logic signed [DW-1:0]   in_hist1;
    logic signed [DW-1:0]   next_in_hist1;
    logic signed [DW-1:0]   in_hist2;
    logic signed [DW-1:0]   next_in_hist2;
    logic signed [DW-1:0]   out_hist2;
    logic signed [DW-1:0]   next_out_hist2;
    logic signed [DW-1:0]   next_out_data;
    logic                   next_out_valid;
    logic                   acq_tick;

    assign acq_tick = (acq_count == CNT_LAST);                        // RULE6

    always_comb
    begin
        next_acq_count = acq_count;
        next_in_hist1  = in_hist1;
        next_in_hist2  = in_hist2;
        next_out_hist2 = out_hist2;
        next_out_data  = out_data;
        next_out_valid = 1'b0;
        if (!nrst)
        begin
            next_acq_count = '0;
            next_in_hist1  = DW'(IN_HIST_RESET);                      // RULE7
            next_in_hist2  = DW'(IN_HIST_RESET);
            // Sync reset, so loading a port value here is safe
            next_out_data  = output_start_value;                      // RULE5
            next_out_hist2 = output_start_value;                      // RULE5
        end
        else if (acq_tick)
        begin
            next_acq_count = '0;
            next_out_data  = filt_calc(pole_two, in_data, in_hist1, in_hist2,
                                       out_data, out_hist2,
                                       numer_weight_newest, numer_weight_middle,
                                       numer_weight_oldest, denom_weight_newer,
                                       denom_weight_oldest);          // RULE1 RULE2
            next_in_hist1  = in_data;
            next_in_hist2  = in_hist1;                                // RULE4
            next_out_hist2 = out_data;                                // RULE4
            next_out_valid = 1'b1;                                    // RULE6
        end
        else
        begin
            next_acq_count = acq_count + 1'b1;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        acq_count <= next_acq_count;
        in_hist1  <= next_in_hist1;
        in_hist2  <= next_in_hist2;
        out_hist2 <= next_out_hist2;
        out_data  <= next_out_data;
        out_valid <= next_out_valid;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    // Cycles since the last output, to check the sample spacing
    logic [CNTW-1:0] gap;
    logic            gap_seen;

    always_ff @(posedge clk_sys)
    begin
        if (!nrst)
        begin
            gap      <= '0;
            gap_seen <= 1'b0;
        end
        else if (out_valid)
        begin
            gap      <= '0;
            gap_seen <= 1'b1;
        end
        else if (gap != CNT_LAST)
        begin
            gap <= gap + 1'b1;
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);

    AST_ONE_POLE_EQN: assert property ( // RULE1
        out_valid && !$past(pole_two) |->
            out_data == sat_q(mul($past(numer_weight_middle), $past(in_data))
                            + mul($past(numer_weight_oldest), $past(in_hist1))
                            - mul($past(denom_weight_oldest), $past(out_data))))
        else $error("one-pole output does not match difference equation");

    AST_TWO_POLE_EQN: assert property ( // RULE2
        out_valid && $past(pole_two) |->
            out_data == sat_q(mul($past(numer_weight_newest), $past(in_data))
                            + mul($past(numer_weight_middle), $past(in_hist1))
                            + mul($past(numer_weight_oldest), $past(in_hist2))
                            - mul($past(denom_weight_newer), $past(out_data))
                            - mul($past(denom_weight_oldest), $past(out_hist2))))
        else $error("two-pole output does not match difference equation");

    AST_ONE_POLE_HIST: assert property ( // RULE3
        out_valid |-> in_hist1 == $past(in_data) && out_hist2 == $past(out_data))
        else $error("previous input or output not captured on sample");

    AST_TWO_POLE_SHIFT: assert property ( // RULE4
        out_valid |-> in_hist2 == $past(in_hist1))
        else $error("two-back input history did not shift");

    AST_START_VALUE: assert property ( // RULE5
        $rose(nrst) |-> out_data == $past(output_start_value)
                        && out_hist2 == $past(output_start_value) && !out_valid)
        else $error("output does not start at start value");

    // The gap reaches CNT_LAST on the tick edge itself, so it is read in the strobe cycle
    AST_ACQ_SPACING: assert property ( // RULE6
        out_valid && gap_seen |-> gap == CNT_LAST)
        else $error("samples not spaced by acquisition time");

    // A saturated gap with no strobe means a tick came late or not at all
    AST_ACQ_NOT_LATE: assert property ( // RULE6
        gap_seen && gap == CNT_LAST |-> out_valid)
        else $error("sample missing after acquisition time");

    AST_VALID_PULSE: assert property ( // RULE6
        ACQ_COUNT > 1 && out_valid |=> !out_valid)
        else $error("sample strobe longer than one cycle");

    AST_HOLD_BETWEEN: assert property ( // RULE6
        !out_valid && $past(nrst) |-> $stable(out_data) && $stable(in_hist1))
        else $error("output or history changed between samples");

    AST_IN_HIST_CLEAR: assert property ( // RULE7
        $rose(nrst) |-> in_hist1 == '0 && in_hist2 == '0)
        else $error("input history not cleared at start");

endmodule

// >>> discrete_iir_filter_tb.sv
// Self-checking bench for the sampled recursive filter
module discrete_iir_filter_tb
    import iir_filter_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, nrst, pole_two, out_valid;
    logic signed [15:0] w_nn, w_nm, w_no, w_dn, w_do, start_v, in_data, out_data, src, taken;
    logic [31:0] seed = 32'hb8431664;
    int n_fail = 0, check_count = 0, n = 0, got;
    longint x1, x2, y1, y2;
    logic signed [15:0] e;
    discrete_iir_filter #(.ACQ_COUNT(4)) DUT (.clk_sys(clk_sys), .nrst(nrst),
        .pole_two(pole_two), .numer_weight_newest(w_nn), .numer_weight_middle(w_nm),
        .numer_weight_oldest(w_no), .denom_weight_newer(w_dn), .denom_weight_oldest(w_do),
        .output_start_value(start_v), .in_data(in_data), .out_data(out_data),
        .out_valid(out_valid));
    sample_peer peer (.clk_sys(clk_sys), .src_word(src), .out_valid(out_valid),
        .in_data(in_data), .taken(taken), .got(got));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    // Floor shift then clamp, as the datapath does
    function automatic logic signed [15:0] model(longint x);
        longint acc;
        if (pole_two)
            acc = w_nn * x + w_nm * x1 + w_no * x2 - w_dn * y1 - w_do * y2;
        else
            acc = w_nm * x + w_no * x1 - w_do * y1;
        acc = acc >>> 14;
        if (acc > 32767) acc = 32767;
        if (acc < -32768) acc = -32768;
        return acc[15:0];
    endfunction
    task automatic chk(string what, logic [15:0] ex, logic [15:0] seen);
        check_count++;
        if (ex !== seen)
        begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, ex, seen);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic cyc(bit sat);
        @(negedge clk_sys);
        if (!nrst)
        begin
            chk("start", start_v, out_data);
            chk("valid_rst", 16'h0000, {15'h0000, out_valid});
            x1 = 0; x2 = 0; y1 = start_v; y2 = start_v; n = 0;
        end
        else
        begin
            n++;
            chk("valid", {15'h0000, n % 4 == 0}, {15'h0000, out_valid});
            if (n % 4 == 0)
            begin
                e = model(taken);
                chk(pole_two ? "two_pole" : "one_pole", e, out_data);
                x2 = x1; x1 = taken; y2 = y1; y1 = e;
            end
        end
        src <= sat ? 16'sh7fff : 16'(xs());
    endtask
    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    initial
    begin
        nrst = 1'b0; pole_two = 1'b0; src = '0; start_v = 16'sh0123;
        {w_nn, w_nm, w_no, w_dn, w_do} = '0;
        repeat (5) cyc(1'b0);
        nrst = 1'b1;
        for (int p = 0; p < 6; p++)
        begin
            pole_two = p[0];
            // Weights kept small so feedback rarely pins the output
            w_nn = 16'($signed(xs()) >>> 18);
            w_nm = 16'($signed(xs()) >>> 18);
            w_no = 16'($signed(xs()) >>> 18);
            w_dn = 16'($signed(xs()) >>> 18);
            w_do = 16'($signed(xs()) >>> 18);
            if (p >= 4) {w_nn, w_nm, w_no} = {3{16'sh7fff}};
            if (p == 3)
            begin
                nrst = 1'b0; start_v = 16'sh8000;
                repeat (2) cyc(1'b0);
                nrst = 1'b1;
            end
            repeat (60) cyc(p >= 4);
        end
        chk("consumed", 16'h0000, {15'h0000, got == 0});
        wrap_up();
    end
endmodule

// >>> iir_filter_pkg.sv
// Shared constants for the one-pole / two-pole sampled recursive filter
package iir_filter_pkg;

    localparam int CLK_PERIOD_NS          = 25;
    localparam int SAMPLE_ACQUIRE_TIME_NS = 1000;
    // Longest spacing rounds down, never below one cycle
    localparam int ACQ_CYCLES             = (SAMPLE_ACQUIRE_TIME_NS / CLK_PERIOD_NS) < 1 ?
                                            1 : (SAMPLE_ACQUIRE_TIME_NS / CLK_PERIOD_NS);
    localparam int DATA_WIDTH             = 16;
    localparam int COEF_WIDTH             = 16;
    localparam int COEF_FRAC              = 14;
    localparam int IN_HIST_RESET          = 0;

endpackage

// >>> sample_peer.sv
// Upstream sample source and downstream consumer for the filter bench
module sample_peer
(
    input  wire logic               clk_sys,   // System clock
    input  wire logic signed [15:0] src_word,  // Next word from the bench
    input  wire logic               out_valid, // New filtered sample strobe
    output logic signed [15:0]      in_data,   // Sample offered to the filter
    output logic signed [15:0]      taken,     // Sample present at last rising edge
    output int                      got        // Filtered samples consumed
);
    timeunit 1ns;
    timeprecision 1ps;
    int consumed = 0;
    assign got = consumed;
    // New word every cycle, so sampling off the tick picks the wrong one
    always @(negedge clk_sys) in_data <= src_word;
    always @(posedge clk_sys) taken <= in_data;
    always @(posedge clk_sys) if (out_valid) consumed <= consumed + 1;
endmodule
